/* File: gcs_lp_model.sv */
// Link partner model giving its role settings, seed and abilities
`timescale 1ns/1ps
module gcs_lp_model
	import gcs_pkg::*;
(
	// Scenario choice
	input wire logic [1:0] lp_mode,
	// Partner lines
	output logic lp_man_en,
	output logic lp_man_val,
	output logic lp_port,
	output logic [gcs_pkg::GCS_SEED_W-1:0] lp_seed,
	output logic lp_gig_full,
	output logic lp_gig_half,
	output logic remote_receiver_ok
);
	// Mode 2 manual master, 1 multi-port, 3 copies the bench's local seed so attempts fail
	always_comb begin
		lp_man_en = lp_mode == 2'h2;
		lp_man_val = GCS_ROLE_MASTER;
		lp_port = lp_mode == 2'h1 ? GCS_PORT_MULTI : GCS_PORT_SINGLE;
		lp_seed = lp_mode == 2'h3 ? 11'h005 : 11'h003;
		lp_gig_full = lp_mode[1];
		lp_gig_half = lp_mode == 2'h3;
		remote_receiver_ok = lp_mode[0];
	end
endmodule

/* File: gcs_pkg.sv */
// Package with offsets, field layout, reset values and codes of the gigabit control/status pair
package gcs_pkg;

	// Register addresses on the management port
	localparam logic [4:0] GCS_CTRL_ADDR = 5'h09;
	localparam logic [4:0] GCS_STAT_ADDR = 5'h0a;

	// Reset values
	localparam logic [15:0] GCS_CTRL_RESET = 16'h0300;
	localparam logic [15:0] GCS_STAT_RESET = 16'h0000;

	// Control field positions
	localparam int GCS_C_TEST_HI = 15;
	localparam int GCS_C_TEST_LO = 13;
	localparam int GCS_C_MAN_EN = 12;
	localparam int GCS_C_MAN_VAL = 11;
	localparam int GCS_C_PORT = 10;
	localparam int GCS_C_ADV_FD = 9;
	localparam int GCS_C_ADV_HD = 8;

	// Status field positions
	localparam int GCS_S_FAULT = 15;
	localparam int GCS_S_ROLE = 14;
	localparam int GCS_S_LRX = 13;
	localparam int GCS_S_RRX = 12;
	localparam int GCS_S_LP_FD = 11;
	localparam int GCS_S_LP_HD = 10;

	// Reserved control bits 7:0 and status bits 9:0 read back as zero
	localparam logic [7:0] GCS_CTRL_RSVD_RD = 8'h00;
	localparam logic [9:0] GCS_STAT_RSVD_RD = 10'h000;

	// Transmitter test codes
	typedef enum logic [2:0] {
		GCS_TEST_NORMAL = 3'b000,
		GCS_TEST_ONE = 3'b001,
		GCS_TEST_TWO = 3'b010,
		GCS_TEST_FOUR = 3'b100,
		GCS_TEST_RSVD = 3'b101,
		GCS_TEST_CABLE = 3'b110,
		GCS_TEST_SPARE = 3'b111
	} gcs_test_type;

	// Failed resolution attempts that raise the fault
	localparam logic [2:0] GCS_FAIL_LIMIT = 3'd7;

	// Seed width for automatic role resolution
	localparam int GCS_SEED_W = 11;

	// Roles and port types
	localparam logic GCS_ROLE_SLAVE = 1'b0;
	localparam logic GCS_ROLE_MASTER = 1'b1;
	localparam logic GCS_PORT_SINGLE = 1'b0;
	localparam logic GCS_PORT_MULTI = 1'b1;

endpackage

/* File: gcs_regs.sv */
// Gigabit control and status register pair with role resolution and test-mode outputs
`timescale 1ns/1ps

// Functional notes
// - Control bits 15:13 pick the transmitter test: 000 normal, 001 waveform, 010 master jitter, 100 distortion.
// - Test code 101 does nothing defined and code 110 starts a cable diagnostic; slave jitter shares code 010.
// - Control bit 12 set to one enables manual role selection, and when zero the manual value is ignored.
// - Control bit 11 forces slave (0) or master (1) in negotiation only while bit 12 is one.
// - Control bit 10 advertises single-port (0) or multi-port (1) and feeds role resolution.
// - Control bit 9 advertises gigabit full duplex and reads one while converter mode holds.
// - Control bit 8 advertises gigabit half duplex and reads one while converter mode holds.
// - Control bits 7:0 are reserved, software writes zero and reads of them carry no meaning.
// - Status bit 15 latches a role configuration fault and is cleared by a status read, unless a new fault lands in that cycle.
// - The fault flag also clears when auto-negotiation is enabled and when it completes.
// - Failed resolution attempts are counted and the fault is set when the count reaches seven.
// - Status bit 14 shows the resolved local role, slave zero and master one.
// - Status bit 13 reads one when the local receiver is fine.
// - Status bit 12 reads one when the remote receiver is reported fine.
// - Status bits 11 and 10 show the partner's gigabit full and half duplex abilities.
// - Status bits 9:8 are reserved and bits 7:0 return no idle error count.
module gcs_regs
	import gcs_pkg::*;
#(
	parameter int SEED_W = gcs_pkg::GCS_SEED_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Management register port
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic mgmt_rd,
	output logic [15:0] mgmt_rdata,
	// Converter mode strap pin
	input wire logic converter_mode,
	// Negotiation events and partner abilities
	input wire logic an_enable,
	input wire logic an_complete,
	input wire logic resolve_start,
	input wire logic lp_man_en,
	input wire logic lp_man_val,
	input wire logic lp_port,
	input wire logic [SEED_W-1:0] loc_seed,
	input wire logic [SEED_W-1:0] lp_seed,
	input wire logic lp_gig_full,
	input wire logic lp_gig_half,
	// Receiver status
	input wire logic local_receiver_ok,
	input wire logic remote_receiver_ok,
	// Controls to the line side
	output logic [2:0] transmit_test_select,
	output logic cable_check_start,
	output logic manual_role_enable,
	output logic forced_role_value,
	output logic port_type_select,
	output logic adv_gig_full_duplex,
	output logic adv_gig_half_duplex,
	// Resolution results
	output logic resolved_role,
	output logic resolve_done
);

	// Address match helper used by both read and write paths
	function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction

	logic conv_sync;
	logic ctrl_wr;
	logic stat_rd;
	logic ctrl_rd;

	// Control state
	logic [2:0] test_r;
	logic [2:0] test_nxt;
	logic man_en_r;
	logic man_en_nxt;
	logic man_val_r;
	logic man_val_nxt;
	logic port_r;
	logic port_nxt;
	logic adv_fd_r;
	logic adv_fd_nxt;
	logic adv_hd_r;
	logic adv_hd_nxt;
	logic cable_r;
	logic cable_nxt;

	// Status state
	logic fault_r;
	logic fault_nxt;
	logic an_en_d_r;
	logic an_en_d_nxt;
	logic an_cpl_d_r;
	logic an_cpl_d_nxt;
	logic lrx_r;
	logic lrx_nxt;
	logic rrx_r;
	logic rrx_nxt;
	logic lp_fd_r;
	logic lp_fd_nxt;
	logic lp_hd_r;
	logic lp_hd_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;

	// Resolver outputs
	logic res_role;
	logic res_done;
	logic res_fault;
	logic an_en_rise;
	logic an_cpl_rise;
	logic [15:0] ctrl_view;
	logic [15:0] stat_view;

	// Converter mode comes from a pin, so it is synchronised first
	gcs_sync2 #(
		.RESET_VAL(1'b0)
	) u_conv_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(converter_mode),
		.sync_out(conv_sync)
	);

	// The resolver only sees the manual value while manual mode is on
	gcs_role_resolve #(
		.SEED_W(SEED_W)
	) u_resolve (
		.core_clk(core_clk),
		.rst(rst),
		.start(resolve_start),
		.restart(an_en_rise),
		.loc_man_en(man_en_r),
		.loc_man_val(man_en_r & man_val_r),
		.loc_port(port_r),
		.loc_seed(loc_seed),
		.lp_man_en(lp_man_en),
		.lp_man_val(lp_man_val),
		.lp_port(lp_port),
		.lp_seed(lp_seed),
		.role(res_role),
		.done(res_done),
		.fault(res_fault)
	);

	// Access decode
	always_comb begin
		ctrl_wr = mgmt_wr && addr_hit(mgmt_addr, GCS_CTRL_ADDR);
		ctrl_rd = mgmt_rd && addr_hit(mgmt_addr, GCS_CTRL_ADDR);
		stat_rd = mgmt_rd && addr_hit(mgmt_addr, GCS_STAT_ADDR);
		an_en_rise = an_enable && !an_en_d_r;
		an_cpl_rise = an_complete && !an_cpl_d_r;
	end

	// Control register next state
	always_comb begin
		test_nxt = test_r;
		man_en_nxt = man_en_r;
		man_val_nxt = man_val_r;
		port_nxt = port_r;
		adv_fd_nxt = adv_fd_r;
		adv_hd_nxt = adv_hd_r;
		cable_nxt = 1'b0;
		if (ctrl_wr) begin
			test_nxt = mgmt_wdata[GCS_C_TEST_HI:GCS_C_TEST_LO];
			man_en_nxt = mgmt_wdata[GCS_C_MAN_EN];
			man_val_nxt = mgmt_wdata[GCS_C_MAN_VAL];
			port_nxt = mgmt_wdata[GCS_C_PORT];
			adv_fd_nxt = mgmt_wdata[GCS_C_ADV_FD];
			adv_hd_nxt = mgmt_wdata[GCS_C_ADV_HD];
			// Diagnostic is kicked once per write of its code, not held
			cable_nxt = (mgmt_wdata[GCS_C_TEST_HI:GCS_C_TEST_LO] == GCS_TEST_CABLE);
			// Bits 7:0 are dropped; nothing stores them
		end
		// Converter mode overrides whatever software left in the duplex bits
		if (conv_sync) begin
			adv_fd_nxt = 1'b1;
			adv_hd_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			test_r <= GCS_CTRL_RESET[GCS_C_TEST_HI:GCS_C_TEST_LO];
			man_en_r <= GCS_CTRL_RESET[GCS_C_MAN_EN];
			man_val_r <= GCS_CTRL_RESET[GCS_C_MAN_VAL];
			port_r <= GCS_CTRL_RESET[GCS_C_PORT];
			adv_fd_r <= GCS_CTRL_RESET[GCS_C_ADV_FD];
			adv_hd_r <= GCS_CTRL_RESET[GCS_C_ADV_HD];
			cable_r <= 1'b0;
		end else begin
			test_r <= test_nxt;
			man_en_r <= man_en_nxt;
			man_val_r <= man_val_nxt;
			port_r <= port_nxt;
			adv_fd_r <= adv_fd_nxt;
			adv_hd_r <= adv_hd_nxt;
			cable_r <= cable_nxt;
		end
	end

	// Fault flag: a new fault in the clearing cycle survives, so set beats clear
	always_comb begin
		fault_nxt = fault_r;
		if (stat_rd) begin
			fault_nxt = 1'b0;
		end
		if (an_en_rise || an_cpl_rise) begin
			fault_nxt = 1'b0;
		end
		if (res_fault) begin
			fault_nxt = 1'b1;
		end
		an_en_d_nxt = an_enable;
		an_cpl_d_nxt = an_complete;
		lrx_nxt = local_receiver_ok;
		rrx_nxt = remote_receiver_ok;
		lp_fd_nxt = lp_gig_full;
		lp_hd_nxt = lp_gig_half;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fault_r <= GCS_STAT_RESET[GCS_S_FAULT];
			an_en_d_r <= 1'b0;
			an_cpl_d_r <= 1'b0;
			lrx_r <= GCS_STAT_RESET[GCS_S_LRX];
			rrx_r <= GCS_STAT_RESET[GCS_S_RRX];
			lp_fd_r <= GCS_STAT_RESET[GCS_S_LP_FD];
			lp_hd_r <= GCS_STAT_RESET[GCS_S_LP_HD];
		end else begin
			fault_r <= fault_nxt;
			an_en_d_r <= an_en_d_nxt;
			an_cpl_d_r <= an_cpl_d_nxt;
			lrx_r <= lrx_nxt;
			rrx_r <= rrx_nxt;
			lp_fd_r <= lp_fd_nxt;
			lp_hd_r <= lp_hd_nxt;
		end
	end

	// Read views; reserved fields read as zero
	always_comb begin
		ctrl_view = {test_r, man_en_r, man_val_r, port_r, adv_fd_r, adv_hd_r,
			GCS_CTRL_RSVD_RD};
		stat_view = {fault_r, res_role, lrx_r, rrx_r, lp_fd_r, lp_hd_r,
			GCS_STAT_RSVD_RD};
	end

	// Read data is captured at the strobe edge and held until the next read
	always_comb begin
		rdata_nxt = rdata_r;
		if (ctrl_rd) begin
			rdata_nxt = ctrl_view;
		end else if (stat_rd) begin
			// The flag is shown as it stood before this read clears it
			rdata_nxt = stat_view;
		end else if (mgmt_rd) begin
			rdata_nxt = 16'h0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign mgmt_rdata = rdata_r;
	assign transmit_test_select = test_r;
	assign cable_check_start = cable_r;
	assign manual_role_enable = man_en_r;
	assign forced_role_value = man_val_r;
	assign port_type_select = port_r;
	assign adv_gig_full_duplex = adv_fd_r;
	assign adv_gig_half_duplex = adv_hd_r;
	assign resolved_role = res_role;
	assign resolve_done = res_done;

endmodule

/* File: gcs_regs_properties.sv */
// Checker of the gigabit control and status port behaviour
`timescale 1ns/1ps
module gcs_regs_chk
	import gcs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [4:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic mgmt_rd,
	input wire logic [15:0] mgmt_rdata,
	// Pins and events
	input wire logic converter_mode,
	input wire logic an_enable,
	input wire logic resolve_start,
	input wire logic lp_man_en,
	input wire logic lp_port,
	input wire logic local_receiver_ok,
	input wire logic remote_receiver_ok,
	// Line side and results
	input wire logic [2:0] transmit_test_select,
	input wire logic cable_check_start,
	input wire logic manual_role_enable,
	input wire logic forced_role_value,
	input wire logic port_type_select,
	input wire logic adv_gig_full_duplex,
	input wire logic adv_gig_half_duplex,
	input wire logic resolved_role,
	input wire logic resolve_done
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Decoded accesses
	logic rd_st, rd_ct, wr_ct;
	assign rd_st = mgmt_rd && mgmt_addr == GCS_STAT_ADDR;
	assign rd_ct = mgmt_rd && mgmt_addr == GCS_CTRL_ADDR;
	assign wr_ct = mgmt_wr && mgmt_addr == GCS_CTRL_ADDR;
	// Status read, then the next one two cycles on; a fault lands two cycles after
	// its attempt, so the attempts before the first read must be quiet too
	sequence s_two_rd;
		!resolve_start ##1 (rd_st && !resolve_start) ##2 rd_st;
	endsequence
	// Negotiation enabled with no fault landing around it, then a status read
	sequence s_an_rd;
		!resolve_start ##1 ($rose(an_enable) && !resolve_start) ##1 (!resolve_start) [*2]
			##1 rd_st;
	endsequence
	property p_test;
		wr_ct |=> transmit_test_select == $past(mgmt_wdata[15:13]);
	endproperty
	a_test: assert property (p_test) else $error("test select not taken");
	property p_cable;
		cable_check_start == $past(wr_ct && mgmt_wdata[15:13] == 3'b110);
	endproperty
	a_cable: assert property (p_cable) else $error("cable start wrong");
	property p_rdclr;
		s_two_rd |=> !mgmt_rdata[15];
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("fault not cleared by read");
	property p_an;
		s_an_rd |=> !mgmt_rdata[15];
	endproperty
	a_an: assert property (p_an) else $error("fault not cleared by enable");
	property p_lrx;
		local_receiver_ok [*2] ##0 rd_st |=> mgmt_rdata[13];
	endproperty
	a_lrx: assert property (p_lrx) else $error("local receiver bit wrong");
	property p_rrx;
		!remote_receiver_ok [*2] ##0 rd_st |=> !mgmt_rdata[12];
	endproperty
	a_rrx: assert property (p_rrx) else $error("remote receiver bit wrong");
	property p_srsvd;
		rd_st |=> mgmt_rdata[9:0] == 10'h000;
	endproperty
	a_srsvd: assert property (p_srsvd) else $error("status low bits not zero");
	property p_crsvd;
		rd_ct |=> mgmt_rdata[7:0] == 8'h00;
	endproperty
	a_crsvd: assert property (p_crsvd) else $error("control low bits not zero");
	property p_adv_fd;
		converter_mode [*5] |-> adv_gig_full_duplex;
	endproperty
	a_adv_fd: assert property (p_adv_fd) else $error("full duplex not forced");
	property p_adv_hd;
		converter_mode [*5] |-> adv_gig_half_duplex;
	endproperty
	a_adv_hd: assert property (p_adv_hd) else $error("half duplex not forced");
	property p_man;
		resolve_start && manual_role_enable && !lp_man_en
			|=> resolve_done && resolved_role == $past(forced_role_value);
	endproperty
	a_man: assert property (p_man) else $error("manual role not used");
	property p_port;
		resolve_start && !manual_role_enable && !lp_man_en && port_type_select && !lp_port
			|=> resolve_done && resolved_role;
	endproperty
	a_port: assert property (p_port) else $error("multi port not master");
endmodule

bind gcs_regs gcs_regs_chk chk_u (
	.core_clk(core_clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
	.mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
	.converter_mode(converter_mode), .an_enable(an_enable), .resolve_start(resolve_start),
	.lp_man_en(lp_man_en), .lp_port(lp_port), .local_receiver_ok(local_receiver_ok),
	.remote_receiver_ok(remote_receiver_ok), .transmit_test_select(transmit_test_select),
	.cable_check_start(cable_check_start), .manual_role_enable(manual_role_enable),
	.forced_role_value(forced_role_value), .port_type_select(port_type_select),
	.adv_gig_full_duplex(adv_gig_full_duplex), .adv_gig_half_duplex(adv_gig_half_duplex),
	.resolved_role(resolved_role), .resolve_done(resolve_done));

/* File: gcs_regs_test.sv */
// Self-checking bench for the gigabit control and status pair
`timescale 1ns/1ps
module gcs_regs_test;
	import gcs_pkg::*;
	// Stimulus
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] mgmt_addr = 5'h00;
	logic mgmt_wr = 1'b0;
	logic [15:0] mgmt_wdata = 16'h0000;
	logic mgmt_rd = 1'b0;
	logic converter_mode = 1'b0;
	logic an_enable = 1'b0;
	logic an_complete = 1'b0;
	logic resolve_start = 1'b0;
	logic local_receiver_ok = 1'b0;
	logic [GCS_SEED_W-1:0] loc_seed = 11'h005;
	logic [1:0] lp_mode = 2'h0;
	// Observed lines
	logic [15:0] mgmt_rdata;
	logic [2:0] tts;
	logic cable, man, frc, prt, afd, ahd, role, done, lme, lmv, lpt, lfd, lhd, rrx;
	logic [GCS_SEED_W-1:0] lps;
	int error_cnt = 0;
	int compares = 0;
	int i;
	// Codes and resolution table: control word, partner mode, expected role
	logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [15:0] rc [6] = '{16'h1000, 16'h1800, 16'h0800, 16'h0400, 16'h0000, 16'h0400};
	logic [1:0] rm [6] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
	logic rr [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

	always #2.5 core_clk = ~core_clk;

	gcs_lp_model lp_u (.lp_mode(lp_mode), .lp_man_en(lme), .lp_man_val(lmv), .lp_port(lpt),
		.lp_seed(lps), .lp_gig_full(lfd), .lp_gig_half(lhd), .remote_receiver_ok(rrx));

	gcs_regs dut_u (.core_clk(core_clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
		.mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
		.converter_mode(converter_mode), .an_enable(an_enable), .an_complete(an_complete),
		.resolve_start(resolve_start), .lp_man_en(lme), .lp_man_val(lmv), .lp_port(lpt),
		.loc_seed(loc_seed), .lp_seed(lps), .lp_gig_full(lfd), .lp_gig_half(lhd),
		.local_receiver_ok(local_receiver_ok), .remote_receiver_ok(rrx),
		.transmit_test_select(tts), .cable_check_start(cable), .manual_role_enable(man),
		.forced_role_value(frc), .port_type_select(prt), .adv_gig_full_duplex(afd),
		.adv_gig_half_duplex(ahd), .resolved_role(role), .resolve_done(done));

	// Comparison with counting
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Expected status word from the fault flag, the role, the local receiver line and the partner's present lines
	function automatic logic [15:0] st(input logic f, input logic r);
		st = {f, r, local_receiver_ok, lp_mode[0], lp_mode[1], lp_mode == 2'h3, 10'h000};
	endfunction
	// One-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		mgmt_addr <= a;
		mgmt_wdata <= d;
		mgmt_wr <= 1'b1;
		@(posedge core_clk);
		mgmt_wr <= 1'b0;
	endtask
	// One-cycle read strobe, data compared under a mask after the taking edge
	task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge core_clk);
		mgmt_addr <= a;
		mgmt_rd <= 1'b1;
		@(posedge core_clk);
		mgmt_rd <= 1'b0;
		#1 chk("rdata", mgmt_rdata & m, e & m);
	endtask
	// One attempt; the answer has a fixed one-cycle latency
	task automatic resolve();
		@(posedge core_clk);
		resolve_start <= 1'b1;
		@(posedge core_clk);
		resolve_start <= 1'b0;
		#1 chk("done", {15'h0000, done}, 16'h0001);
	endtask
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(GCS_CTRL_ADDR, GCS_CTRL_RESET, 16'hffff);
		rd(GCS_STAT_ADDR, GCS_STAT_RESET, 16'hffff);
		rd(5'h1f, 16'h0000, 16'hffff);
		$display("reset test done");
		// Every test code, reserved control bits written as zero
		foreach (codes[k]) begin
			wr(GCS_CTRL_ADDR, {codes[k], 13'h0000});
			#1 chk("test", {13'h0000, tts}, {13'h0000, codes[k]});
			chk("cable", {15'h0000, cable}, {15'h0000, codes[k] == 3'b110});
			rd(GCS_CTRL_ADDR, {codes[k], 13'h0000}, 16'hffff);
		end
		wr(GCS_CTRL_ADDR, 16'h1c00);
		#1 chk("ctrl", {11'h000, man, frc, prt, afd, ahd}, 16'h001c);
		$display("code test done");
		// Role resolution table
		for (i = 0; i < 6; i++) begin
			wr(GCS_CTRL_ADDR, rc[i]);
			lp_mode <= rm[i];
			resolve();
			chk("role", {15'h0000, role}, {15'h0000, rr[i]});
			rd(GCS_STAT_ADDR, st(1'b0, rr[i]), 16'hffff);
		end
		$display("role test done");
		// Failed attempts: the seventh sets the flag and a read clears it
		wr(GCS_CTRL_ADDR, 16'h0000);
		lp_mode <= 2'h3;
		local_receiver_ok <= 1'b1;
		an_enable <= 1'b1;
		repeat (6) resolve();
		rd(GCS_STAT_ADDR, st(1'b0, rr[5]), 16'hffff);
		resolve();
		rd(GCS_STAT_ADDR, st(1'b1, rr[5]), 16'hffff);
		rd(GCS_STAT_ADDR, st(1'b0, rr[5]), 16'hffff);
		// Both ends manual master is a fault; negotiation events clear it
		wr(GCS_CTRL_ADDR, 16'h1800);
		lp_mode <= 2'h2;
		resolve();
		rd(GCS_STAT_ADDR, 16'h8000, 16'h8000);
		resolve();
		// Raise after the fault has landed: a set in the clearing cycle would win
		@(posedge core_clk);
		an_complete <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(GCS_STAT_ADDR, 16'h0000, 16'h8000);
		@(posedge core_clk);
		an_enable <= 1'b0;
		resolve();
		@(posedge core_clk);
		an_enable <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(GCS_STAT_ADDR, 16'h0000, 16'h8000);
		$display("fault test done");
		// Converter mode holds both advertised bits at one
		wr(GCS_CTRL_ADDR, 16'h0000);
		converter_mode <= 1'b1;
		repeat (5) @(posedge core_clk);
		wr(GCS_CTRL_ADDR, 16'h0000);
		rd(GCS_CTRL_ADDR, 16'h0300, 16'hffff);
		chk("adv", {14'h0000, afd, ahd}, 16'h0003);
		@(posedge core_clk);
		converter_mode <= 1'b0;
		repeat (4) @(posedge core_clk);
		wr(GCS_CTRL_ADDR, 16'h0000);
		rd(GCS_CTRL_ADDR, 16'h0000, 16'hffff);
		$display("converter test done");
		wrap_up();
	end
endmodule

/* File: gcs_role_resolve.sv */
// Master/slave role resolution with failed-attempt counting
`timescale 1ns/1ps
module gcs_role_resolve
	import gcs_pkg::*;
#(
	parameter int SEED_W = gcs_pkg::GCS_SEED_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Attempt request and counter restart
	input wire logic start,
	input wire logic restart,
	// Local settings
	input wire logic loc_man_en,
	input wire logic loc_man_val,
	input wire logic loc_port,
	input wire logic [SEED_W-1:0] loc_seed,
	// Link partner settings
	input wire logic lp_man_en,
	input wire logic lp_man_val,
	input wire logic lp_port,
	input wire logic [SEED_W-1:0] lp_seed,
	// Results
	output logic role,
	output logic done,
	output logic fault
);

	typedef enum logic [1:0] {
		GCS_RES_MASTER = 2'b00,
		GCS_RES_SLAVE = 2'b01,
		GCS_RES_RETRY = 2'b10,
		GCS_RES_CONFLICT = 2'b11
	} gcs_res_type;

	logic role_r;
	logic role_nxt;
	logic done_r;
	logic done_nxt;
	logic fault_r;
	logic fault_nxt;
	logic [2:0] fail_cnt_r;
	logic [2:0] fail_cnt_nxt;
	gcs_res_type outcome;

	// One attempt: manual settings first, then port type, then seeds
	function automatic gcs_res_type decide(input logic lme, input logic lmv, input logic lpt,
		input logic [SEED_W-1:0] ls, input logic pme, input logic pmv, input logic ppt,
		input logic [SEED_W-1:0] ps);
		if (lme && pme) begin
			decide = (lmv == pmv) ? GCS_RES_CONFLICT :
				(lmv ? GCS_RES_MASTER : GCS_RES_SLAVE);
		end else if (lme) begin
			decide = lmv ? GCS_RES_MASTER : GCS_RES_SLAVE;
		end else if (pme) begin
			decide = pmv ? GCS_RES_SLAVE : GCS_RES_MASTER;
		end else if (lpt != ppt) begin
			decide = (lpt == GCS_PORT_MULTI) ? GCS_RES_MASTER : GCS_RES_SLAVE;
		end else if (ls == ps) begin
			decide = GCS_RES_RETRY;
		end else begin
			decide = (ls > ps) ? GCS_RES_MASTER : GCS_RES_SLAVE;
		end
	endfunction

	always_comb begin
		outcome = decide(loc_man_en, loc_man_val, loc_port, loc_seed,
			lp_man_en, lp_man_val, lp_port, lp_seed);
	end

	// Attempt bookkeeping; a restart in the same cycle as an attempt lets the attempt count
	always_comb begin
		role_nxt = role_r;
		done_nxt = 1'b0;
		fault_nxt = 1'b0;
		fail_cnt_nxt = restart ? 3'd0 : fail_cnt_r;
		if (start) begin
			done_nxt = 1'b1;
			case (outcome)
				GCS_RES_MASTER: begin
					role_nxt = GCS_ROLE_MASTER;
					fail_cnt_nxt = 3'd0;
				end
				GCS_RES_SLAVE: begin
					role_nxt = GCS_ROLE_SLAVE;
					fail_cnt_nxt = 3'd0;
				end
				GCS_RES_CONFLICT: begin
					fault_nxt = 1'b1;
					fail_cnt_nxt = 3'd0;
				end
				GCS_RES_RETRY: begin
					// Count clears to zero at the limit and raises the fault on reaching it
					if (fail_cnt_nxt + 3'd1 >= GCS_FAIL_LIMIT) begin
						fault_nxt = 1'b1;
						fail_cnt_nxt = 3'd0;
					end else begin
						fail_cnt_nxt = fail_cnt_nxt + 3'd1;
					end
				end
				default: begin
					fault_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			role_r <= GCS_ROLE_SLAVE;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			fail_cnt_r <= 3'd0;
		end else begin
			role_r <= role_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			fail_cnt_r <= fail_cnt_nxt;
		end
	end

	assign role = role_r;
	assign done = done_r;
	assign fault = fault_r;

endmodule

/* File: gcs_sync2.sv */
// Two-flop synchroniser for a level arriving from a pin
`timescale 1ns/1ps
module gcs_sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	// First stage is read only by the second stage
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule
